// ---- verilog/ar_codec_defs.vh ----
// constants for the address-resolution message codec
// assumes: included by the codec only, one 200 MHz clock
// Contract
// - precedence 0-1:4, 2-3:3, 4-5:2, 6-7:1
// - frame priority field is priority minus one
// - precedence is traffic class top three bits
// - stateless address compression always supported
// - negotiated compression never used for multicast
// - messages open with defined 8-bit type
// - bind request: 16, network, hardware address
// - unbind request: 18, network, hardware address
// - lookup request: 20, network address only
// - lookup succeeds only when result is zero
// - group bind request: 24, group address
// - acks matched to pending requests by address
// - four contention priority levels, 1 to 4
// - resend request after one second without answer
`ifndef AR_CODEC_DEFS_VH
`define AR_CODEC_DEFS_VH

`define MT_BIND_REQ     8'h10
`define MT_BIND_ACK     8'h11
`define MT_UNBIND_REQ   8'h12
`define MT_UNBIND_ACK   8'h13
`define MT_LOOKUP_REQ   8'h14
`define MT_LOOKUP_RSP   8'h15
`define MT_GROUP_REQ    8'h18
`define MT_GROUP_ACK    8'h19

`define KIND_BIND       2'h0
`define KIND_UNBIND     2'h1
`define KIND_LOOKUP     2'h2
`define KIND_GROUP      2'h3

`define LOOKUP_FOUND    8'h00
`define LOOKUP_UNKNOWN  8'h01

`define NET_BYTES       16
`define HW_BYTES        6
// message lengths in bytes
`define LEN_ADDR_PAIR   8'h17
`define LEN_NET_ONLY    8'h11
`define LEN_LOOKUP_RSP  8'h18
`define LEN_GROUP_ACK   8'h12

`define RETRY_TIME_NS   1000000000
`define CLK_PERIOD_NS   5

`endif

// ---- verilog/ar_skid_buffer.v ----
// two-entry byte buffer between the serializer and the link
// assumes: source and sink on the same clock
`timescale 1ns/100ps
module ar_skid_buffer #(
    parameter WIDTH = 8
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem_reg [0:1];
    reg             wptr_reg;
    reg             rptr_reg;
    reg [1:0]       count_reg;
    wire            push;
    wire            pop;

    assign in_ready  = (count_reg != 2'h2);
    assign out_valid = (count_reg != 2'h0);
    assign out_data  = mem_reg[rptr_reg];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge clk) begin
        if (!rst_n) begin
            wptr_reg  <= 1'b0;
            rptr_reg  <= 1'b0;
            count_reg <= 2'h0;
        end else begin
            if (push) begin
                mem_reg[wptr_reg] <= in_data;
                wptr_reg          <= ~wptr_reg;
            end
            if (pop)
                rptr_reg <= ~rptr_reg;
            if (push & ~pop)
                count_reg <= count_reg + 2'h1;
            else if (pop & ~push)
                count_reg <= count_reg - 2'h1;
        end
    end
endmodule

// ---- verilog/ar_pdu_codec.v ----
// address-resolution message builder and parser, priority mapper
// assumes: byte stream link to the base node, one clock, sync reset
`timescale 1ns/100ps
`include "ar_codec_defs.vh"
module ar_pdu_codec #(
    parameter PENDING     = 4,
    parameter RETRY_TICKS = `RETRY_TIME_NS / `CLK_PERIOD_NS
) (
    input  wire         clk,
    input  wire         rst_n,
    // request side
    input  wire         req_valid,
    output wire         req_ready,
    input  wire [1:0]   req_kind,
    input  wire [127:0] req_net_addr,
    input  wire [47:0]  req_hw_addr,
    // outgoing byte stream
    output wire [7:0]   tx_data,
    output wire         tx_valid,
    input  wire         tx_ready,
    output wire         tx_last,
    // incoming byte stream
    input  wire [7:0]   rx_data,
    input  wire         rx_valid,
    input  wire         rx_last,
    // results
    output reg          done_valid,
    output reg  [1:0]   done_kind,
    output reg          done_ok,
    output reg  [127:0] done_net_addr,
    output reg  [47:0]  done_hw_addr,
    output reg  [5:0]   done_channel,
    // priority and compression
    input  wire [7:0]   traffic_class,
    input  wire         dest_multicast,
    input  wire [1:0]   negotiated_hc,
    output reg  [1:0]   frame_priority_field,
    output reg  [2:0]   access_priority,
    output reg          stateless_comp_en,
    output reg  [1:0]   applied_hc
);
    localparam ST_IDLE = 1'b0;
    localparam ST_SEND = 1'b1;
    localparam TW = 32;

    // pending table, one entry per outstanding request
    reg           pv_reg   [0:PENDING-1];
    reg [1:0]     pk_reg   [0:PENDING-1];
    reg [127:0]   pn_reg   [0:PENDING-1];
    reg [47:0]    ph_reg   [0:PENDING-1];
    reg [TW-1:0]  pt_reg   [0:PENDING-1];

    reg           state_reg;
    reg [183:0]   shift_reg;
    reg [7:0]     left_reg;
    reg [7:0]     rxc_reg;
    reg [207:0]   rxb_reg;
    reg [7:0]     rx_d1_reg, rx_d2_reg;
    reg           rx_v1_reg, rx_v2_reg, rx_l1_reg, rx_l2_reg;
    reg [1:0]     resend_slot_reg;
    reg           resend_reg;

    wire          buf_ready;
    wire          buf_push = (state_reg == ST_SEND);
    wire [207:0]  frame = {rxb_reg[199:0], rx_d2_reg};
    wire [7:0]    rx_type = frame[8*rxc_reg +: 8];

    ar_skid_buffer #(.WIDTH(9)) u_buf (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_data   ({left_reg == 8'h01, shift_reg[183:176]}),
        .in_valid  (buf_push),
        .in_ready  (buf_ready),
        .out_data  ({tx_last, tx_data}),
        .out_valid (tx_valid),
        .out_ready (tx_ready)
    );

    // free slot search and expired slot search
    reg [1:0] free_idx;
    reg       free_any;
    reg [1:0] exp_idx;
    reg       exp_any;
    integer   i;
    always @* begin
        free_idx = 2'h0;
        free_any = 1'b0;
        exp_idx  = 2'h0;
        exp_any  = 1'b0;
        for (i = PENDING - 1; i >= 0; i = i - 1) begin
            if (!pv_reg[i]) begin
                free_idx = i[1:0];
                free_any = 1'b1;
            end
            if (pv_reg[i] && pt_reg[i] == 0) begin
                exp_idx = i[1:0];
                exp_any = 1'b1;
            end
        end
    end

    // new requests only when a pending slot is free and no resend waits
    assign req_ready = (state_reg == ST_IDLE) & free_any & ~exp_any;

    // only defined request codes are built
    function [7:0] req_code;
        input [1:0] k;
        begin
            case (k)
                `KIND_BIND:   req_code = `MT_BIND_REQ;
                `KIND_UNBIND: req_code = `MT_UNBIND_REQ;
                `KIND_LOOKUP: req_code = `MT_LOOKUP_REQ;
                default:      req_code = `MT_GROUP_REQ;
            endcase
        end
    endfunction

    function [7:0] req_len;
        input [1:0] k;
        begin
            req_len = (k == `KIND_BIND || k == `KIND_UNBIND) ? `LEN_ADDR_PAIR
                                                             : `LEN_NET_ONLY;
        end
    endfunction

    reg       start;
    reg [1:0] s_kind;
    reg [127:0] s_net;
    reg [47:0]  s_hw;
    always @* begin
        start  = 1'b0;
        s_kind = req_kind;
        s_net  = req_net_addr;
        s_hw   = req_hw_addr;
        if (state_reg == ST_IDLE && exp_any) begin
            start  = 1'b1;
            s_kind = pk_reg[exp_idx];
            s_net  = pn_reg[exp_idx];
            s_hw   = ph_reg[exp_idx];
        end else if (req_valid && req_ready) begin
            start = 1'b1;
        end
    end

    // transmit serializer
    always @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            shift_reg <= 184'h0;
            left_reg  <= 8'h00;
        end else if (state_reg == ST_IDLE) begin
            if (start) begin
                shift_reg <= {req_code(s_kind), s_net, s_hw};
                left_reg  <= req_len(s_kind);
                state_reg <= ST_SEND;
            end
        end else if (buf_ready) begin
            shift_reg <= {shift_reg[175:0], 8'h00};
            left_reg  <= left_reg - 8'h01;
            if (left_reg == 8'h01)
                state_reg <= ST_IDLE;
        end
    end

    // receive path: pins from the link pass two flops
    always @(posedge clk) begin
        if (!rst_n) begin
            rx_v1_reg <= 1'b0;
            rx_v2_reg <= 1'b0;
            rx_l1_reg <= 1'b0;
            rx_l2_reg <= 1'b0;
            rx_d1_reg <= 8'h00;
            rx_d2_reg <= 8'h00;
            rxc_reg   <= 8'h00;
            rxb_reg   <= 208'h0;
        end else begin
            rx_v1_reg <= rx_valid;
            rx_v2_reg <= rx_v1_reg;
            rx_l1_reg <= rx_last;
            rx_l2_reg <= rx_l1_reg;
            rx_d1_reg <= rx_data;
            rx_d2_reg <= rx_d1_reg;
            if (rx_v2_reg) begin
                rxb_reg <= frame;
                rxc_reg <= rx_l2_reg ? 8'h00 : rxc_reg + 8'h01;
            end
        end
    end

    // decode a whole message, msb first, lengths checked per type
    reg         m_ok;
    reg [1:0]   m_kind;
    reg [127:0] m_net;
    reg [47:0]  m_hw;
    reg [7:0]   m_res;
    reg [5:0]   m_ch;
    always @* begin
        m_ok   = 1'b0;
        m_kind = `KIND_BIND;
        m_net  = 128'h0;
        m_hw   = 48'h0;
        m_res  = `LOOKUP_FOUND;
        m_ch   = 6'h00;
        if (rx_v2_reg && rx_l2_reg) begin
            if ((rx_type == `MT_BIND_ACK || rx_type == `MT_UNBIND_ACK)
                && rxc_reg == `LEN_ADDR_PAIR - 8'h01) begin
                m_ok   = 1'b1;
                m_kind = (rx_type == `MT_BIND_ACK) ? `KIND_BIND : `KIND_UNBIND;
                m_net  = frame[175:48];
                m_hw   = frame[47:0];
            end else if (rx_type == `MT_LOOKUP_RSP
                         && rxc_reg == `LEN_LOOKUP_RSP - 8'h01) begin
                m_ok   = 1'b1;
                m_kind = `KIND_LOOKUP;
                m_net  = frame[183:56];
                m_hw   = frame[55:8];
                m_res  = frame[7:0];
            end else if (rx_type == `MT_GROUP_ACK
                         && rxc_reg == `LEN_GROUP_ACK - 8'h01) begin
                m_ok   = 1'b1;
                m_kind = `KIND_GROUP;
                m_net  = frame[135:8];
                m_ch   = frame[5:0];
            end
        end
    end

    // match answer to a pending request by echoed addresses
    reg [1:0] hit_idx;
    reg       hit;
    integer   j;
    always @* begin
        hit_idx = 2'h0;
        hit     = 1'b0;
        for (j = PENDING - 1; j >= 0; j = j - 1) begin
            if (m_ok && pv_reg[j] && pk_reg[j] == m_kind && pn_reg[j] == m_net
                && (m_kind == `KIND_LOOKUP || m_kind == `KIND_GROUP
                    || ph_reg[j] == m_hw)) begin
                hit_idx = j[1:0];
                hit     = 1'b1;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < PENDING; g = g + 1) begin : g_slot
            always @(posedge clk) begin
                if (!rst_n) begin
                    pv_reg[g] <= 1'b0;
                    pk_reg[g] <= 2'h0;
                    pn_reg[g] <= 128'h0;
                    ph_reg[g] <= 48'h0;
                    pt_reg[g] <= {TW{1'b0}};
                end else if (hit && hit_idx == g) begin
                    pv_reg[g] <= 1'b0;
                end else if (state_reg == ST_IDLE && start && exp_any
                             && exp_idx == g) begin
                    pt_reg[g] <= RETRY_TICKS[TW-1:0];
                end else if (state_reg == ST_IDLE && start && !exp_any
                             && free_idx == g) begin
                    pv_reg[g] <= 1'b1;
                    pk_reg[g] <= req_kind;
                    pn_reg[g] <= req_net_addr;
                    ph_reg[g] <= req_hw_addr;
                    pt_reg[g] <= RETRY_TICKS[TW-1:0];
                end else if (pv_reg[g] && pt_reg[g] != 0) begin
                    pt_reg[g] <= pt_reg[g] - {{(TW-1){1'b0}}, 1'b1};
                end
            end
        end
    endgenerate

    // result report and priority/compression mapping
    always @(posedge clk) begin
        if (!rst_n) begin
            done_valid           <= 1'b0;
            done_kind            <= 2'h0;
            done_ok              <= 1'b0;
            done_net_addr        <= 128'h0;
            done_hw_addr         <= 48'h0;
            done_channel         <= 6'h00;
            frame_priority_field <= 2'h3;
            access_priority      <= 3'h4;
            stateless_comp_en    <= 1'b1;
            applied_hc           <= 2'h0;
        end else begin
            done_valid    <= hit;
            done_kind     <= m_kind;
            done_ok       <= (m_kind != `KIND_LOOKUP) | (m_res == `LOOKUP_FOUND);
            done_net_addr <= m_net;
            // unknown lookups report no hardware address
            done_hw_addr  <= (m_kind == `KIND_LOOKUP && m_res != `LOOKUP_FOUND)
                             ? 48'h0 : m_hw;
            done_channel  <= m_ch;
            // levels 1..4 from precedence, top bits of traffic class
            access_priority      <= 3'h4 - {1'b0, traffic_class[7:6]};
            frame_priority_field <= 2'h3 - traffic_class[7:6];
            stateless_comp_en    <= 1'b1;
            applied_hc           <= dest_multicast ? 2'h0 : negotiated_hc;
        end
    end
endmodule

// ---- tb/ar_codec_monitor.sv ----
// port checker for the address-resolution codec
// assumes: bound to ar_pdu_codec, one clock, sync reset
`timescale 1ns/100ps
module ar_codec_monitor (
    input wire         clk,
    input wire         rst_n,
    input wire [7:0]   tx_data,
    input wire         tx_valid,
    input wire         tx_ready,
    input wire         tx_last,
    input wire         done_valid,
    input wire [1:0]   done_kind,
    input wire         done_ok,
    input wire [47:0]  done_hw_addr,
    input wire [7:0]   traffic_class,
    input wire         dest_multicast,
    input wire [1:0]   negotiated_hc,
    input wire [1:0]   frame_priority_field,
    input wire [2:0]   access_priority,
    input wire         stateless_comp_en,
    input wire [1:0]   applied_hc
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire [1:0] prec = traffic_class[7:6];
    reg        first_reg;
    reg [4:0]  cnt_reg;
    reg [7:0]  type_reg;
    always @(posedge clk) begin
        if (!rst_n) begin
            first_reg <= 1'b1;
            cnt_reg   <= 5'h0;
            type_reg  <= 8'h0;
        end else if (tx_valid && tx_ready) begin
            first_reg <= tx_last;
            cnt_reg   <= tx_last ? 5'h0 : cnt_reg + 5'h1;
            if (first_reg) type_reg <= tx_data;
        end
    end
    AST_PRIO: assert property ($past(rst_n) |-> access_priority ==
        (($past(prec) == 2'h0) ? 3'h4 : ($past(prec) == 2'h1) ? 3'h3
            : ($past(prec) == 2'h2) ? 3'h2 : 3'h1))
        else $error("priority map wrong");
    AST_FPF: assert property ({1'b0, frame_priority_field} == access_priority - 3'h1)
        else $error("frame priority not priority minus one");
    AST_SLC: assert property (stateless_comp_en)
        else $error("stateless compression off");
    AST_HC: assert property ($past(rst_n) |->
        applied_hc == ($past(dest_multicast) ? 2'h0 : $past(negotiated_hc)))
        else $error("compression choice wrong");
    AST_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("tx byte dropped under stall");
    AST_TYPE: assert property (tx_valid && first_reg |->
        tx_data inside {8'h10, 8'h12, 8'h14, 8'h18})
        else $error("bad type code sent");
    AST_LEN: assert property (tx_valid && tx_ready && tx_last |->
        cnt_reg == ((type_reg == 8'h10 || type_reg == 8'h12) ? 5'h16 : 5'h10))
        else $error("message length wrong");
    AST_OK: assert property (done_valid && done_kind != 2'h2 |-> done_ok)
        else $error("non-lookup result failed");
    AST_UNK: assert property (done_valid && !done_ok |-> done_hw_addr == 48'h0)
        else $error("unknown lookup gave hardware address");
endmodule
bind ar_pdu_codec ar_codec_monitor i_mon (.clk, .rst_n, .tx_data, .tx_valid, .tx_ready,
    .tx_last, .done_valid, .done_kind, .done_ok, .done_hw_addr, .traffic_class,
    .dest_multicast, .negotiated_hc, .frame_priority_field, .access_priority,
    .stateless_comp_en, .applied_hc);

// ---- tb/base_model.sv ----
// base node model: echoes each request as its acknowledgment
// assumes: handles one message at a time, replies in arrival order
`timescale 1ns/100ps
module base_model (
    input  wire       clk,
    input  wire [7:0] tx_data,
    input  wire       tx_valid,
    output reg        tx_ready,
    input  wire       tx_last,
    output reg  [7:0] rx_data,
    output reg        rx_valid,
    output reg        rx_last,
    input  wire       silent,
    input  wire       stall,
    input  wire [7:0] result,
    input  wire [7:0] delay
);
    reg [7:0] msg [0:23];
    reg [7:0] rsp [0:23];
    reg [7:0] k;
    integer   n = 0, len = 0, rcvd = 0, sent = 0, m, i;
    always @(posedge clk) begin
        tx_ready <= stall ? ~tx_ready : 1'b1;
        if (tx_valid && tx_ready) begin
            msg[n] <= tx_data;
            n <= tx_last ? 0 : n + 1;
            if (tx_last) begin
                len  <= n + 1;
                rcvd <= rcvd + 1;
            end
        end
    end
    // duplicates answered like any other request
    initial begin
        rx_valid = 1'b0;
        rx_last  = 1'b0;
        rx_data  = 8'h0;
        forever begin
            @(posedge clk);
            if (rcvd != sent) begin
                sent = rcvd;
                k = msg[0];
                rsp[0] = k + 8'h1;
                m = (k < 8'h14) ? 23 : (k == 8'h14) ? 24 : 18;
                for (i = 1; i < 23; i = i + 1)
                    rsp[i] = (k == 8'h14 && i > 16) ? 8'hA0 + i[7:0] : msg[i];
                if (k == 8'h14) rsp[23] = result;
                if (k == 8'h18) rsp[17] = 8'h2A;
                if (!silent) begin
                    repeat (delay) @(posedge clk);
                    for (i = 0; i < m; i = i + 1) begin
                        rx_data  <= rsp[i];
                        rx_valid <= 1'b1;
                        rx_last  <= (i == m - 1);
                        @(posedge clk);
                    end
                    rx_valid <= 1'b0;
                    rx_last  <= 1'b0;
                    rx_data  <= ~rsp[m-1];
                end
            end
        end
    end
endmodule

// ---- tb/tb.sv ----
// bench for the address-resolution codec
// assumes: codec with a short retry time, base_model on the link
`timescale 1ns/100ps
module tb;
    reg clk = 0, rst_n = 0, req_valid = 0, dest_multicast = 0, silent = 0, stall = 0;
    reg [1:0] req_kind = 0, negotiated_hc = 0;
    reg [127:0] req_net_addr = 0;
    reg [47:0] req_hw_addr = 0;
    reg [7:0] traffic_class = 0, result = 0, delay = 8'h2;
    wire req_ready, tx_valid, tx_ready, tx_last, rx_valid, rx_last, done_valid, done_ok;
    wire stateless_comp_en;
    wire [7:0] tx_data, rx_data;
    wire [1:0] done_kind, frame_priority_field, applied_hc;
    wire [127:0] done_net_addr;
    wire [47:0] done_hw_addr;
    wire [5:0] done_channel;
    wire [2:0] access_priority;
    integer mismatches = 0, comparisons = 0, cyc = 0;
    ar_pdu_codec #(.RETRY_TICKS(200)) i_ar_pdu_codec (.clk, .rst_n, .req_valid, .req_ready,
        .req_kind, .req_net_addr, .req_hw_addr, .tx_data, .tx_valid, .tx_ready, .tx_last,
        .rx_data, .rx_valid, .rx_last, .done_valid, .done_kind, .done_ok, .done_net_addr,
        .done_hw_addr, .done_channel, .traffic_class, .dest_multicast, .negotiated_hc,
        .frame_priority_field, .access_priority, .stateless_comp_en, .applied_hc);
    base_model i_base_model (.clk, .tx_data, .tx_valid, .tx_ready, .tx_last, .rx_data,
        .rx_valid, .rx_last, .silent, .stall, .result, .delay);
    always #2.5 clk = ~clk;
    task results;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, mismatches);
            if (mismatches == 0 && comparisons > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            mismatches = mismatches + 1;
            results;
        end
    end
    task chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("[FAIL] %s exp %0h seen %0h", what, exp, seen);
            end
        end
    endtask
    task send(input [1:0] k, input [127:0] a, input [47:0] h);
        integer t;
        begin
            t = 0;
            @(negedge clk);
            while (req_ready !== 1'b1 && t < 500) begin
                @(negedge clk);
                t = t + 1;
            end
            {req_kind, req_net_addr, req_hw_addr} = {k, a, h};
            req_valid = 1'b1;
            @(negedge clk);
            req_valid = 1'b0;
        end
    endtask
    task wait_done(input integer lim);
        integer t;
        begin
            t = 0;
            while (done_valid !== 1'b1 && t < lim) begin
                @(negedge clk);
                t = t + 1;
            end
            chk("done", done_valid, 1'b1);
        end
    endtask
    task t_prio;
        integer p;
        begin
            for (p = 0; p < 8; p = p + 1) begin
                @(negedge clk);
                traffic_class = {p[2:0], 5'h15};
                {dest_multicast, negotiated_hc} = {p[2], p[1:0]};
                @(negedge clk);
                chk("prio", access_priority, 4 - p / 2);
                chk("fpf", frame_priority_field, 3 - p / 2);
                chk("hc", applied_hc, p[2] ? 2'h0 : p[1:0]);
                chk("slc", stateless_comp_en, 1'b1);
            end
        end
    endtask
    task t_xfer(input [1:0] k, input [127:0] a, input [47:0] h, input [7:0] res);
        integer i;
        begin
            result = res;
            send(k, a, h);
            wait_done(200);
            chk("kind", done_kind, k);
            chk("net", done_net_addr, a);
            chk("ok", done_ok, !(k == 2'h2 && res != 8'h0));
            if (k < 2'h2) chk("hw", done_hw_addr, h);
            if (k == 2'h2) chk("hw", done_hw_addr, res ? 48'h0 : 48'hB1B2B3B4B5B6);
            if (k == 2'h3) chk("chan", done_channel, 6'h2A);
            chk("type", i_base_model.msg[0], 8'h10 + 2 * k + (k == 2'h3 ? 2 : 0));
            chk("len", i_base_model.len, (k < 2'h2) ? 23 : 17);
            for (i = 0; i < 22; i = i + 1)
                if (i < 16 || k < 2'h2)
                    chk("byte", i_base_model.msg[i+1], {a, h} >> (168 - 8 * i) & 8'hFF);
            @(negedge clk);
            chk("pulse", done_valid, 1'b0);
        end
    endtask
    task t_overlap;
        begin
            delay = 8'h28;
            send(2'h0, 128'h1, 48'h1);
            chk("busy", req_ready, 1'b0);
            send(2'h0, 128'h2, 48'h2);
            wait_done(200);
            chk("first", done_net_addr, 128'h1);
            @(negedge clk);
            wait_done(200);
            chk("second", done_net_addr, 128'h2);
            delay = 8'h2;
        end
    endtask
    task t_retry;
        integer n, r0;
        begin
            silent = 1'b1;
            r0 = i_base_model.rcvd;
            send(2'h2, 128'hFE80, 48'h0);
            n = 0;
            while (i_base_model.rcvd < r0 + 2 && n < 400) begin
                @(negedge clk);
                n = n + 1;
            end
            chk("resend", n > 190 && n < 260, 1'b1);
            silent = 1'b0;
            wait_done(600);
            chk("late", done_net_addr, 128'hFE80);
        end
    endtask
    initial begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        chk("rst_prio", access_priority, 3'h4);
        chk("rst_ready", req_ready, 1'b1);
        chk("rst_tx", tx_valid, 1'b0);
        rst_n = 1'b1;
        t_prio;
        stall = 1'b1;
        t_xfer(2'h0, 128'h0123456789ABCDEFFEDCBA9876543210, 48'hA1B2C3D4E5F6, 8'h0);
        t_xfer(2'h1, 128'hFFEEDDCCBBAA99887766554433221100, 48'h0C0FFEE0BEEF, 8'h0);
        stall = 1'b0;
        t_xfer(2'h2, 128'h20010DB8000000000000000000000001, 48'h0, 8'h0);
        t_xfer(2'h2, 128'h20010DB8000000000000000000000002, 48'h0, 8'h1);
        t_xfer(2'h3, 128'hFF020000000000000000000000000001, 48'h0, 8'h0);
        t_overlap;
        t_retry;
        results;
    end
endmodule
